//--- stop_limit_pkg.sv
/*
 * Shared constants for the per-axis stop, servo and limit qualifier:
 * axis count, mode register field positions, error bit positions.
 * Assumes one chip clock and that every user includes this package.
 */
package stop_limit_pkg;

    localparam int NUM_AXES  = 4;
    localparam int NUM_STOPS = 3;
    localparam int MODE_W    = 16;
    localparam int POS_W     = 32;
    localparam int ERR_W     = 5;
    localparam int AXIS_IDX_W = 2;

    // Synchronised inputs per axis: three stops, inpos, alarm, +lim, -lim
    localparam int IN_PER_AXIS = 7;
    localparam int SYNC_W      = NUM_AXES * IN_PER_AXIS;
    localparam int IN_INPOS    = 3;
    localparam int IN_ALARM    = 4;
    localparam int IN_PLIM     = 5;
    localparam int IN_MLIM     = 6;

    // stop_limit_mode_reg fields
    localparam int STOP_POL_BIT0     = 0;
    localparam int STOP_EN_BIT0      = 1;
    localparam int STOP_FIELD_STRIDE = 2;
    localparam int INPOS_POL_BIT     = 6;
    localparam int INPOS_EN_BIT      = 7;
    localparam int ALARM_POL_BIT     = 8;
    localparam int ALARM_EN_BIT      = 9;
    localparam int HWL_POL_BIT       = 10;
    localparam int HWL_EN_BIT        = 11;
    localparam int HWL_STOP_TYPE_BIT = 12;
    localparam int SWL_EN_BIT        = 13;
    localparam int SWL_SRC_BIT       = 14;
    localparam int SWL_STOP_TYPE_BIT = 15;
    localparam logic [MODE_W-1:0] MODE_RESET = 16'h0000;

    // error_status_reg bits
    localparam int ERR_SWL_PLUS  = 0;
    localparam int ERR_SWL_MINUS = 1;
    localparam int ERR_HWL_PLUS  = 2;
    localparam int ERR_HWL_MINUS = 3;
    localparam int ERR_ALARM     = 4;

endpackage

//--- mode_mem_if.sv
/*
 * Carrier between the qualifier top and its mode register store.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/100ps
interface mode_mem_if;
    import stop_limit_pkg::*;

    logic                                  wr_en;
    logic [NUM_AXES-1:0]                   wr_mask;
    logic [MODE_W-1:0]                     wdata;
    logic [AXIS_IDX_W-1:0]                 rd_idx;
    logic [MODE_W-1:0]                     rdata;
    logic [NUM_AXES-1:0][MODE_W-1:0]       modes;

    modport owner (output wr_en, wr_mask, wdata, rd_idx,
                   input  rdata, modes);
    modport store (input  wr_en, wr_mask, wdata, rd_idx,
                   output rdata, modes);
endinterface

//--- mode_store.sv
/*
 * One stop_limit_mode_reg copy per axis, multi-axis write by mask,
 * registered read of one axis. Assumes the owner holds rd_idx steady.
 */
`timescale 1ns/100ps
module mode_store (
    input  wire logic  ref_clk,
    input  wire logic  arst_n,
    mode_mem_if.store  mif
);
    import stop_limit_pkg::*;

    logic [NUM_AXES-1:0][MODE_W-1:0] mode_q;
    logic [NUM_AXES-1:0][MODE_W-1:0] mode_d;
    logic [MODE_W-1:0]               rdata_q;
    logic [MODE_W-1:0]               rdata_d;

    always_comb begin
        for (int a = 0; a < NUM_AXES; a++) begin
            mode_d[a] = (mif.wr_en && mif.wr_mask[a]) ? mif.wdata
                                                      : mode_q[a];
        end
        rdata_d = mode_q[mif.rd_idx];
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int a = 0; a < NUM_AXES; a++) begin
                mode_q[a] <= MODE_RESET;
            end
            rdata_q <= MODE_RESET;
        end else begin
            mode_q  <= mode_d;
            rdata_q <= rdata_d;
        end
    end

    assign mif.modes = mode_q;
    assign mif.rdata = rdata_q;
endmodule

//--- axis_stop_limit_servo_input_control.sv
/*
 * Per-axis qualification of external stop, servo and limit inputs and
 * software limit checking for a four-axis pulse motion controller.
 * Assumes the pulse generator reports busy/direction/acc mode and acts
 * on the stop outputs; position counters and limit values come from
 * elsewhere on the same clock. Pins are asynchronous.
 */
// Notes on behaviour
// - One mode register per axis; access follows the last commanded axis.
// - Each stop input has a polarity bit, 0 low active, 1 high.
// - Each stop input has an enable bit; disabled inputs are ignored.
// - In-position input polarity bit, 0 low active, 1 high active.
// - With in-position check, busy stays high until in-position active.
// - Servo alarm polarity bit, 0 low active, 1 high active.
// - Enabled alarm active while driving sets error bit 4, stops.
// - Plus and minus hardware limits share one polarity bit.
// - Enabled limits in matching direction set bits 2/3 and stop.
// - Hardware limit stop type: 0 instant, 1 decelerating.
// - Enabled software limits set bits 0/1 in matching direction.
// - Plus software error when position at or above plus limit.
// - Minus software error when position strictly below minus limit.
// - Drive starts toward a direction in software error are refused.
// - Software limit compares logical counter at 0, real at 1.
// - Software limit stop type: 0 decelerating, 1 instant.
// - Reset clears every axis mode register to zero.
`timescale 1ns/100ps
module axis_stop_limit_servo_input_control (
    input  wire logic                                          ref_clk,
    input  wire logic                                          arst_n,
    input  wire logic                                          cmd_wr,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]           cmd_axis,
    input  wire logic                                          mode_wr,
    input  wire logic [stop_limit_pkg::MODE_W-1:0]             mode_wdata,
    output logic      [stop_limit_pkg::MODE_W-1:0]             mode_rdata,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]
                      [stop_limit_pkg::NUM_STOPS-1:0]          ext_stop_in,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]           servo_in_position,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]           servo_alarm_in,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]           plus_limit_in,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]           minus_limit_in,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]           pulse_busy,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]           drive_dir_minus,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]           accel_drive,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]
                      [stop_limit_pkg::POS_W-1:0]              logic_pos,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]
                      [stop_limit_pkg::POS_W-1:0]              real_pos,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]
                      [stop_limit_pkg::POS_W-1:0]              plus_sw_limit,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]
                      [stop_limit_pkg::POS_W-1:0]              minus_sw_limit,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]           start_req,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]           start_dir_minus,
    output logic      [stop_limit_pkg::NUM_AXES-1:0]           start_refused,
    input  wire logic [stop_limit_pkg::NUM_AXES-1:0]           err_clear,
    output logic      [stop_limit_pkg::NUM_AXES-1:0]
                      [stop_limit_pkg::ERR_W-1:0]              error_status_reg,
    output logic      [stop_limit_pkg::NUM_AXES-1:0]           drive_busy,
    output logic      [stop_limit_pkg::NUM_AXES-1:0]           stop_instant,
    output logic      [stop_limit_pkg::NUM_AXES-1:0]           stop_decel
);
    import stop_limit_pkg::*;

    function automatic logic active_level(input logic raw, input logic pol);
        active_level = pol ? raw : ~raw;
    endfunction

    function automatic logic [AXIS_IDX_W-1:0] lowest_axis(
        input logic [NUM_AXES-1:0] mask);
        lowest_axis = '0;
        for (int i = NUM_AXES - 1; i >= 0; i--) begin
            if (mask[i]) begin
                lowest_axis = AXIS_IDX_W'(i);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Axis selection and mode register store

    mode_mem_if mif ();

    logic [NUM_AXES-1:0] axis_sel_q;
    logic [NUM_AXES-1:0] axis_sel_d;

    always_comb begin
        axis_sel_d = cmd_wr ? cmd_axis : axis_sel_q;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            axis_sel_q <= '0;
        end else begin
            axis_sel_q <= axis_sel_d;
        end
    end

    assign mif.wr_en   = mode_wr;
    assign mif.wr_mask = axis_sel_q;
    assign mif.wdata   = mode_wdata;
    // Reads with several axes assigned return the lowest one
    assign mif.rd_idx  = lowest_axis(axis_sel_q);
    assign mode_rdata  = mif.rdata;

    mode_store u_store (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .mif     (mif)
    );

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] sync3_q;
    logic [SYNC_W-1:0] filt_q;
    logic [SYNC_W-1:0] filt_d;

    always_comb begin
        for (int a = 0; a < NUM_AXES; a++) begin
            pins_raw[a*IN_PER_AXIS +: IN_PER_AXIS] =
                {minus_limit_in[a], plus_limit_in[a], servo_alarm_in[a],
                 servo_in_position[a], ext_stop_in[a]};
        end
    end

    always_comb begin
        for (int i = 0; i < SYNC_W; i++) begin
            filt_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : filt_q[i];
        end
    end

    // Filter resets to all ones: idle high, like pulled-up pins
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= '1;
            sync2_q <= '1;
            sync3_q <= '1;
            filt_q  <= '1;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q  <= filt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-axis qualification

    logic [NUM_AXES-1:0][ERR_W-1:0] err_q;
    logic [NUM_AXES-1:0][ERR_W-1:0] err_d;
    logic [NUM_AXES-1:0]            busy_q;
    logic [NUM_AXES-1:0]            busy_d;
    logic [NUM_AXES-1:0]            inst_q;
    logic [NUM_AXES-1:0]            inst_d;
    logic [NUM_AXES-1:0]            dec_q;
    logic [NUM_AXES-1:0]            dec_d;
    logic [NUM_AXES-1:0]            refuse_q;
    logic [NUM_AXES-1:0]            refuse_d;

    always_comb begin
        logic [MODE_W-1:0]      m;
        logic [IN_PER_AXIS-1:0] s;
        logic                   stop_hit;
        logic                   inpos_act;
        logic                   alarm;
        logic                   hw_p;
        logic                   hw_m;
        logic                   sw_p_err;
        logic                   sw_m_err;
        logic                   sw_p;
        logic                   sw_m;
        logic                   run;
        logic                   inst;
        logic                   dec;
        logic signed [POS_W-1:0] comp;
        logic [ERR_W-1:0]       ev;
        m = '0; s = '0; stop_hit = 1'b0; inpos_act = 1'b0;
        alarm = 1'b0; hw_p = 1'b0; hw_m = 1'b0; sw_p_err = 1'b0;
        sw_m_err = 1'b0; sw_p = 1'b0; sw_m = 1'b0; run = 1'b0;
        inst = 1'b0; dec = 1'b0; comp = '0; ev = '0;
        for (int a = 0; a < NUM_AXES; a++) begin
            m   = mif.modes[a];
            s   = filt_q[a*IN_PER_AXIS +: IN_PER_AXIS];
            run = pulse_busy[a];
            stop_hit = 1'b0;
            for (int k = 0; k < NUM_STOPS; k++) begin
                stop_hit = stop_hit
                    | (m[STOP_EN_BIT0 + STOP_FIELD_STRIDE*k]
                       & active_level(s[k],
                                      m[STOP_POL_BIT0 + STOP_FIELD_STRIDE*k]));
            end
            inpos_act = active_level(s[IN_INPOS], m[INPOS_POL_BIT]);
            alarm = m[ALARM_EN_BIT]
                  & active_level(s[IN_ALARM], m[ALARM_POL_BIT]);
            hw_p = m[HWL_EN_BIT] & ~drive_dir_minus[a]
                 & active_level(s[IN_PLIM], m[HWL_POL_BIT]);
            hw_m = m[HWL_EN_BIT] & drive_dir_minus[a]
                 & active_level(s[IN_MLIM], m[HWL_POL_BIT]);
            comp = m[SWL_SRC_BIT] ? $signed(real_pos[a])
                                  : $signed(logic_pos[a]);
            sw_p_err = comp >= $signed(plus_sw_limit[a]);
            sw_m_err = comp < $signed(minus_sw_limit[a]);
            sw_p = m[SWL_EN_BIT] & sw_p_err & ~drive_dir_minus[a];
            sw_m = m[SWL_EN_BIT] & sw_m_err & drive_dir_minus[a];
            // alarm error, limit errors, sw errors
            ev = {alarm, hw_m, hw_p, sw_m, sw_p} & {ERR_W{run}};
            // New events win over a clear in the same cycle
            err_d[a] = ev | (err_q[a] & ~{ERR_W{err_clear[a]}});
            // stop input type, hw type, sw type
            // Alarm has no type bit; stopping at once protects the drive
            inst = alarm
                 | ((hw_p | hw_m) & ~m[HWL_STOP_TYPE_BIT])
                 | ((sw_p | sw_m) & m[SWL_STOP_TYPE_BIT])
                 | (stop_hit & ~accel_drive[a]);
            dec  = ((hw_p | hw_m) & m[HWL_STOP_TYPE_BIT])
                 | ((sw_p | sw_m) & ~m[SWL_STOP_TYPE_BIT])
                 | (stop_hit & accel_drive[a]);
            inst_d[a] = run & inst;
            dec_d[a]  = run & dec & ~inst;
            busy_d[a] = run
                      | (busy_q[a] & m[INPOS_EN_BIT] & ~inpos_act);
            refuse_d[a] = start_req[a] & m[SWL_EN_BIT]
                        & (start_dir_minus[a] ? sw_m_err : sw_p_err);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            err_q    <= '0;
            busy_q   <= '0;
            inst_q   <= '0;
            dec_q    <= '0;
            refuse_q <= '0;
        end else begin
            err_q    <= err_d;
            busy_q   <= busy_d;
            inst_q   <= inst_d;
            dec_q    <= dec_d;
            refuse_q <= refuse_d;
        end
    end

    assign error_status_reg = err_q;
    assign drive_busy       = busy_q;
    assign stop_instant     = inst_q;
    assign stop_decel       = dec_q;
    assign start_refused    = refuse_q;

    ////////////////////////////////////////////////////////////////////
    // Checks on axis 0

    logic [MODE_W-1:0] m0;
    assign m0 = mif.modes[0];

    AST_SEL_WRITE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cmd_wr && cmd_axis == 4'h1 ##1 !cmd_wr ##1 mode_wr && !cmd_wr
        |=> mif.modes[0] == $past(mode_wdata))
        else $error("mode write missed selected axis");

    AST_STOP_EN: assert property (@(posedge ref_clk) disable iff (!arst_n)
        pulse_busy[0] && m0[STOP_EN_BIT0] && accel_drive[0]
        && active_level(filt_q[0], m0[STOP_POL_BIT0])
        |=> stop_decel[0] || stop_instant[0])
        else $error("enabled stop input did not stop axis");

    AST_STOP_CONST: assert property (@(posedge ref_clk) disable iff (!arst_n)
        pulse_busy[0] && m0[STOP_EN_BIT0] && !accel_drive[0]
        && active_level(filt_q[0], m0[STOP_POL_BIT0])
        |=> stop_instant[0] && !stop_decel[0])
        else $error("constant speed stop not instant");

    AST_INPOS_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        drive_busy[0] && !pulse_busy[0] && m0[INPOS_EN_BIT]
        && !active_level(filt_q[IN_INPOS], m0[INPOS_POL_BIT])
        |=> drive_busy[0])
        else $error("busy dropped before in-position");

    AST_ALARM: assert property (@(posedge ref_clk) disable iff (!arst_n)
        pulse_busy[0] && m0[ALARM_EN_BIT]
        && active_level(filt_q[IN_ALARM], m0[ALARM_POL_BIT])
        |=> error_status_reg[0][ERR_ALARM] && stop_instant[0])
        else $error("alarm did not set error and stop");

    AST_HWL_PLUS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        pulse_busy[0] && !drive_dir_minus[0] && m0[HWL_EN_BIT]
        && active_level(filt_q[IN_PLIM], m0[HWL_POL_BIT])
        |=> error_status_reg[0][ERR_HWL_PLUS]
            && (stop_decel[0] || stop_instant[0]))
        else $error("plus hardware limit not flagged");

    AST_SWL_PLUS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        pulse_busy[0] && !drive_dir_minus[0] && m0[SWL_EN_BIT]
        && !m0[SWL_SRC_BIT]
        && $signed(logic_pos[0]) >= $signed(plus_sw_limit[0])
        |=> error_status_reg[0][ERR_SWL_PLUS])
        else $error("plus software limit not flagged");

    AST_REFUSE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        start_req[0] && start_dir_minus[0] && m0[SWL_EN_BIT]
        && (m0[SWL_SRC_BIT] ? $signed(real_pos[0])
                            : $signed(logic_pos[0]))
           < $signed(minus_sw_limit[0])
        |=> start_refused[0])
        else $error("start into minus limit not refused");

    AST_ERR_STICKY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        error_status_reg[0][ERR_ALARM] && !err_clear[0]
        |=> error_status_reg[0][ERR_ALARM])
        else $error("alarm error lost without clear");

endmodule

//--- servo_limit_pins.sv
/*
 * Far-side model: stop sensors, limit switches and servo driver pins.
 * Assumes the bench asks for active/inactive per pin of axis 0 and
 * tells the model the active level; other axes idle high.
 */
`timescale 1ns/100ps
module servo_limit_pins (
    input  wire logic                                     ref_clk,
    input  wire logic                                     slow,
    input  wire logic [stop_limit_pkg::IN_PER_AXIS-1:0]   want,
    input  wire logic [stop_limit_pkg::IN_PER_AXIS-1:0]   act_hi,
    output logic      [stop_limit_pkg::NUM_AXES-1:0]
                      [stop_limit_pkg::NUM_STOPS-1:0]     ext_stop_in,
    output logic      [stop_limit_pkg::NUM_AXES-1:0]      servo_in_position,
    output logic      [stop_limit_pkg::NUM_AXES-1:0]      servo_alarm_in,
    output logic      [stop_limit_pkg::NUM_AXES-1:0]      plus_limit_in,
    output logic      [stop_limit_pkg::NUM_AXES-1:0]      minus_limit_in
);
    import stop_limit_pkg::*;

    logic [IN_PER_AXIS-1:0] late_q;
    logic [IN_PER_AXIS-1:0] lvl;

    ////////////////////////////////////////////////////////////////////
    // Slow mode: a sensor that reacts one clock late
    always_ff @(posedge ref_clk) begin
        late_q <= want;
    end
    assign lvl = (slow ? late_q : want) ~^ act_hi;

    always_comb begin
        ext_stop_in          = '1;
        servo_in_position    = '1;
        servo_alarm_in       = '1;
        plus_limit_in        = '1;
        minus_limit_in       = '1;
        ext_stop_in[0]       = lvl[NUM_STOPS-1:0];
        servo_in_position[0] = lvl[IN_INPOS];
        servo_alarm_in[0]    = lvl[IN_ALARM];
        plus_limit_in[0]     = lvl[IN_PLIM];
        minus_limit_in[0]    = lvl[IN_MLIM];
    end
endmodule

//--- axis_stop_limit_servo_input_control_tb.sv
/*
 * Self-checking bench for the stop/limit/servo qualifier, axis 0 in
 * depth. Assumes the design package and the pin model are compiled.
 */
`timescale 1ns/100ps
module axis_stop_limit_servo_input_control_tb;
    import stop_limit_pkg::*;

    logic                               ref_clk, arst_n, cmd_wr, mode_wr;
    logic [NUM_AXES-1:0]                cmd_axis, busy, dmin, accel, sreq;
    logic [NUM_AXES-1:0]                sdir, srefd, eclr, dbusy, s_ins;
    logic [NUM_AXES-1:0]                s_dec, inpos, alarm, plim, mlim;
    logic [MODE_W-1:0]                  wdata, rdata;
    logic [NUM_AXES-1:0][NUM_STOPS-1:0] stops;
    logic [NUM_AXES-1:0][POS_W-1:0]     lpos, rpos, plimv, mlimv;
    logic [NUM_AXES-1:0][ERR_W-1:0]     err;
    logic [IN_PER_AXIS-1:0]             want, act_hi;
    logic                               slow;
    int                                 n_errors, check_count;

    axis_stop_limit_servo_input_control
        axis_stop_limit_servo_input_control_inst (
        .ref_clk(ref_clk), .arst_n(arst_n), .cmd_wr(cmd_wr),
        .cmd_axis(cmd_axis), .mode_wr(mode_wr), .mode_wdata(wdata),
        .mode_rdata(rdata), .ext_stop_in(stops),
        .servo_in_position(inpos), .servo_alarm_in(alarm),
        .plus_limit_in(plim), .minus_limit_in(mlim), .pulse_busy(busy),
        .drive_dir_minus(dmin), .accel_drive(accel), .logic_pos(lpos),
        .real_pos(rpos), .plus_sw_limit(plimv), .minus_sw_limit(mlimv),
        .start_req(sreq), .start_dir_minus(sdir), .start_refused(srefd),
        .err_clear(eclr), .error_status_reg(err), .drive_busy(dbusy),
        .stop_instant(s_ins), .stop_decel(s_dec));

    servo_limit_pins servo_limit_pins_inst (
        .ref_clk(ref_clk), .slow(slow), .want(want), .act_hi(act_hi),
        .ext_stop_in(stops), .servo_in_position(inpos),
        .servo_alarm_in(alarm), .plus_limit_in(plim),
        .minus_limit_in(mlim));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic cmp(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Single-axis masks only when a read follows
    task automatic sel(input logic [3:0] m);
        cmd_wr = 1'b1;
        cmd_axis = m;
        cyc(1);
        cmd_wr = 1'b0;
        cyc(1);
    endtask

    task automatic wr_mode(input logic [3:0] m, input logic [15:0] d);
        sel(m);
        mode_wr = 1'b1;
        wdata = d;
        cyc(1);
        mode_wr = 1'b0;
        cyc(2);
    endtask

    task automatic rd_mode(input logic [3:0] m, input logic [15:0] exp);
        sel(m);
        cyc(1);
        cmp("mode_rdata", exp, rdata);
    endtask

    // Drive axis 0 with one pin request, then check flags and stops
    task automatic cond(input string what, input logic [15:0] md,
        input logic [6:0] w, input logic dm, input logic ac,
        input logic [31:0] lp, input logic [31:0] rp,
        input logic [4:0] e_err, input logic ei, input logic ed);
        wr_mode(4'h1, md);
        // Idle pins settle at the new polarity before driving starts
        act_hi = {md[10], md[10], md[8], md[6], md[4], md[2], md[0]};
        cyc(5);
        lpos[0] = lp;
        rpos[0] = rp;
        dmin[0] = dm;
        accel[0] = ac;
        busy[0] = 1'b1;
        want = w;
        cyc(7);
        cmp({what, " err"}, 16'(e_err), 16'(err[0]));
        cmp({what, " instant"}, 16'(ei), 16'(s_ins[0]));
        cmp({what, " decel"}, 16'(ed), 16'(s_dec[0]));
        busy[0] = 1'b0;
        want = '0;
        cyc(1);
        eclr[0] = 1'b1;
        cyc(1);
        eclr[0] = 1'b0;
        cyc(6);
        cmp({what, " cleared"}, 16'h0000, 16'(err[0]));
    endtask

    task automatic start(input logic dm, input logic exp);
        sreq[0] = 1'b1;
        sdir[0] = dm;
        cyc(1);
        sreq[0] = 1'b0;
        cmp("start_refused", 16'(exp), 16'(srefd[0]));
        cyc(1);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        {cmd_wr, mode_wr, cmd_axis, busy, dmin, accel, sreq, sdir} = '0;
        {eclr, wdata, want, act_hi, slow} = '0;
        {lpos, rpos} = '0;
        plimv = {NUM_AXES{32'h0000_0064}};
        mlimv = {NUM_AXES{32'hffff_ff9c}};
        arst_n = 1'b0;
        cyc(5);
        arst_n = 1'b1;
        rd_mode(4'h1, 16'h0000);
        wr_mode(4'h2, 16'ha5c3);
        wr_mode(4'hc, 16'h5a3c);
        rd_mode(4'h1, 16'h0000);
        rd_mode(4'h2, 16'ha5c3);
        rd_mode(4'h4, 16'h5a3c);
        rd_mode(4'h8, 16'h5a3c);
        cond("alarm hi", 16'h0300, 7'h10, 0, 0, 0, 0, 5'h10, 1, 0);
        cond("alarm lo", 16'h0200, 7'h10, 0, 0, 0, 0, 5'h10, 1, 0);
        cond("alarm off", 16'h0100, 7'h10, 0, 0, 0, 0, 5'h00, 0, 0);
        slow = 1'b1;
        // Decelerating type kept, as a home search would need
        cond("plus hw", 16'h1c00, 7'h20, 0, 0, 0, 0, 5'h04, 0, 1);
        cond("minus hw", 16'h0800, 7'h40, 1, 1, 0, 0, 5'h08, 1, 0);
        cond("hw wrong dir", 16'h0c00, 7'h20, 1, 0, 0, 0, 5'h00, 0, 0);
        cond("hw off", 16'h0400, 7'h40, 1, 0, 0, 0, 5'h00, 0, 0);
        slow = 1'b0;
        for (int k = 0; k < NUM_STOPS; k++) begin
            cond("stop decel", 16'(3 << 2 * k), 7'(1 << k), 0, 1, 0, 0,
                 5'h00, 0, 1);
            cond("stop instant", 16'(2 << 2 * k), 7'(1 << k), 0, 0, 0, 0,
                 5'h00, 1, 0);
            cond("stop off", 16'(1 << 2 * k), 7'(1 << k), 0, 1, 0, 0,
                 5'h00, 0, 0);
        end
        cond("sw plus", 16'h2000, 7'h00, 0, 0, 100, 0, 5'h01, 0, 1);
        start(1'b0, 1'b1);
        start(1'b1, 1'b0);
        cond("sw below", 16'h2000, 7'h00, 0, 0, 99, 0, 5'h00, 0, 0);
        cond("sw minus", 16'ha000, 7'h00, 1, 1, -101, 0, 5'h02, 1, 0);
        start(1'b1, 1'b1);
        start(1'b0, 1'b0);
        cond("sw at min", 16'h2000, 7'h00, 1, 0, -100, 0, 5'h00, 0, 0);
        cond("sw real", 16'h6000, 7'h00, 0, 0, 0, 100, 5'h01, 0, 1);
        cond("sw real ok", 16'h6000, 7'h00, 0, 0, 100, 0, 5'h00, 0, 0);
        cond("sw dir", 16'h2000, 7'h00, 1, 0, 100, 0, 5'h00, 0, 0);
        wr_mode(4'h1, 16'h00c0);
        act_hi = 7'h08;
        cyc(5);
        busy[0] = 1'b1;
        cyc(2);
        busy[0] = 1'b0;
        cyc(8);
        cmp("drive_busy held", 16'h0001, 16'(dbusy[0]));
        want = 7'h08;
        cyc(6);
        cmp("drive_busy inpos", 16'h0000, 16'(dbusy[0]));
        want = '0;
        wr_mode(4'h1, 16'h0000);
        busy[0] = 1'b1;
        cyc(2);
        busy[0] = 1'b0;
        cyc(2);
        cmp("drive_busy plain", 16'h0000, 16'(dbusy[0]));
        arst_n = 1'b0;
        cyc(2);
        arst_n = 1'b1;
        rd_mode(4'h2, 16'h0000);
        rd_mode(4'h4, 16'h0000);
        give_verdict();
    end

    // Guard against a hung sequence
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        give_verdict();
    end
endmodule
